// >>> bench/axi_host.sv
// Purpose: host side model issuing register accesses over AXI4-Lite
// Assumes: called just after a rising edge of aclk
// Notes: reads ready/valid right after the edge, before the dut updates
`timescale 1ns/100ps
`default_nettype none
module axi_host (
    input wire logic aclk,
    output logic [11:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [11:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // idle bus at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // one write: address and data offered together, each held until taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      output logic [1:0] resp);
        logic a_ok;
        logic w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h000000, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge aclk);
            if (!a_ok && awready) begin
                a_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    // one read: address held until taken, then wait for the data
    task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                      output logic [1:0] resp);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : axi_host
`default_nettype wire

// >>> bench/testbench.sv
// Purpose: self-checking bench for the floppy configuration registers
// Assumes: 20 MHz aclk, synchronous active-low reset
// Notes: table rows first, then hand-written cases
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic wr;
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] ex;
    } row_s;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic wp_n = 1'b1;
    logic dens_req = 1'b0;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic dso, wblk, at_mode, r2m, c48, tri_out, dev_en, enh;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    // reset values, then masked writes read back
    row_s rows [17] = '{
        '{1'b0, 8'h30, 8'h00, 8'h00}, '{1'b0, 8'h60, 8'h00, 8'h03},
        '{1'b0, 8'h61, 8'h00, 8'hF2}, '{1'b0, 8'h70, 8'h00, 8'h06},
        '{1'b0, 8'h71, 8'h00, 8'h03}, '{1'b0, 8'h74, 8'h00, 8'h02},
        '{1'b0, 8'h75, 8'h00, 8'h04}, '{1'b0, 8'hF0, 8'h00, 8'h24},
        '{1'b0, 8'hF1, 8'h00, 8'h00}, '{1'b0, 8'hF8, 8'h00, 8'h24},
        '{1'b1, 8'h60, 8'hFF, 8'h07}, '{1'b1, 8'h61, 8'hFF, 8'hFA},
        '{1'b1, 8'h71, 8'h00, 8'h01}, '{1'b1, 8'h71, 8'hFF, 8'h03},
        '{1'b1, 8'hF1, 8'hFF, 8'h03}, '{1'b1, 8'h75, 8'hFF, 8'h04},
        '{1'b1, 8'h70, 8'h5A, 8'h5A}};
    always #25 aclk = ~aclk;
    axi_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    floppy_config_regs i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .write_protect_n_pin(wp_n),
        .density_req(dens_req), .density_select_out(dso),
        .write_blocked(wblk), .at_drive_mode(at_mode),
        .rate_2m_enable(r2m), .clock_48m_select(c48),
        .outputs_tristate(tri_out), .device_enabled(dev_en),
        .drive_mode_enhanced(enh));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // write, expect okay, let derived outputs and pins settle
    task automatic w(input logic [7:0] i, input logic [7:0] d);
        i_host.wr(i, d, rsp);
        chk("bresp", rsp, fdc_cfg_pkg::RESP_OKAY);
        repeat (5) @(posedge aclk);
    endtask : w
    // read and compare the low byte, upper bits zero
    task automatic r(input logic [7:0] i, input logic [7:0] e);
        i_host.rd(i, rd_d, rsp);
        chk("rdata", rd_d, {24'h000000, e});
    endtask : r
    // verdict
    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    // hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        foreach (rows[i]) begin
            if (rows[i].wr) w(rows[i].idx, rows[i].wd);
            r(rows[i].idx, rows[i].ex);
        end
        $display("table done");
        w(8'hF8, 8'hFF);
        r(8'hF0, 8'h7D);
        chk("enh", enh, 1'b1);
        chk("r2m", {r2m, c48}, 2'h3);
        chk("wblk", wblk, 1'b1);
        chk("tri", tri_out, 1'b1);
        r(8'hE2, 8'hFF);
        w(8'h30, 8'h01);
        chk("en", {dev_en, tri_out}, 2'h2);
        r(8'hE1, 8'h03);
        w(8'hE0, 8'h01);
        chk("off", dev_en, 1'b0);
        r(8'hE1, 8'h06);
        w(8'hE0, 8'h00);
        w(8'hF1, 8'h03);
        w(8'hE2, 8'h00);
        r(8'hE2, 8'h30);
        w(8'hF0, 8'h24);
        r(8'hE2, 8'hFC);
        dens_req <= 1'b1;
        wp_n <= 1'b0;
        w(8'hF8, 8'h24);
        chk("dens", {dso, at_mode, wblk}, 3'h7);
        w(8'hF0, 8'h00);
        chk("dens", {dso, at_mode}, 2'h0);
        wp_n <= 1'b1;
        repeat (5) @(posedge aclk);
        chk("wblk", wblk, 1'b0);
        $display("outputs done");
        i_host.rd(8'h10, rd_d, rsp);
        chk("unmapped_rresp", rsp, fdc_cfg_pkg::RESP_SLVERR);
        chk("unmapped_rdata", rd_d, 32'h0);
        i_host.wr(8'h10, 8'hFF, rsp);
        chk("unmapped_bresp", rsp, fdc_cfg_pkg::RESP_SLVERR);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("rst", {dev_en, tri_out, at_mode}, 3'h1);
        r(8'hF8, 8'h24);
        $display("reset done");
        results();
    end
endmodule : testbench
`default_nettype wire

// >>> rtl/drive_reg_view.sv
// Purpose: builds the drive control register read value
// Assumes: inputs are synchronous to aclk
// Notes: pure combinational view
`timescale 1ns/100ps
`default_nettype none
module drive_reg_view (
    input wire logic enhanced,
    input wire logic drive0_sel,
    input wire logic [1:0] drive_identity,
    input wire logic [1:0] drive_sel,
    output logic [7:0] value
);
    // compose upper and low fields
    always_comb begin
        if (!enhanced) begin
            value = {fdc_cfg_pkg::COMPAT_UPPER, drive_sel};
        end else if (drive0_sel) begin
            value = {2'h0, drive_identity, 2'h0, drive_sel};
        end else begin
            value = {6'h00, drive_sel}; // enhanced, other drive
        end
    end
endmodule : drive_reg_view
`default_nettype wire

// >>> rtl/fdc_cfg_pkg.sv
// Purpose: constants for the floppy configuration register bank
// Assumes: byte indexes of the configuration space, byte address = 4*index
// Notes: reset values and field positions live here only
package fdc_cfg_pkg;
    // register indexes (byte address is four times the index)
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_BASE_HI = 8'h60;
    localparam logic [7:0] IDX_BASE_LO = 8'h61;
    localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
    localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
    localparam logic [7:0] IDX_DMA_SEL = 8'h74;
    localparam logic [7:0] IDX_DMA2_RPT = 8'h75;
    localparam logic [7:0] IDX_CFG = 8'hF0;
    localparam logic [7:0] IDX_DRIVE_IDENTITY = 8'hF1;
    localparam logic [7:0] IDX_CFG_MIRROR = 8'hF8;
    // own control/status registers
    localparam logic [7:0] IDX_FORCE_OFF = 8'hE0;
    localparam logic [7:0] IDX_STATUS = 8'hE1;
    localparam logic [7:0] IDX_DRIVE_CTL = 8'hE2;
    // reset values
    localparam logic [7:0] RST_ACTIVATE = 8'h00;
    localparam logic [7:0] RST_BASE_HI = 8'h03;
    localparam logic [7:0] RST_BASE_LO = 8'hF2;
    localparam logic [7:0] RST_IRQ_NUM = 8'h06;
    localparam logic [7:0] RST_IRQ_TYPE = 8'h03;
    localparam logic [7:0] RST_DMA_SEL = 8'h02;
    localparam logic [7:0] RST_DMA2_RPT = 8'h04;
    localparam logic [7:0] RST_CFG = 8'h24;
    localparam logic [7:0] RST_DRIVE_IDENTITY = 8'h00;
    localparam logic [7:0] RST_DRIVE_CTL = 8'h00;
    // writable masks
    localparam logic [7:0] WMASK_BASE_HI = 8'h07;
    localparam logic [7:0] WMASK_BASE_LO = 8'hFA;
    localparam logic [7:0] WMASK_IRQ_TYPE = 8'h02;
    localparam logic [7:0] WMASK_CFG = 8'h7D;
    localparam logic [7:0] WMASK_DRIVE_IDENTITY = 8'h03;
    localparam logic [7:0] WMASK_ACTIVATE = 8'h01;
    // configuration field positions
    localparam int CFG_TRISTATE = 0;
    localparam int CFG_AT_MODE = 2;
    localparam int CFG_FORCE_WP = 3;
    localparam int CFG_RATE_2M = 4;
    localparam int CFG_DENS_POL = 5;
    localparam int CFG_ENHANCED = 6;
    // drive control register fields
    localparam int DCTL_DRIVE_SEL = 0;
    localparam logic [5:0] COMPAT_UPPER = 6'h3F;
    // controller clock choice, MHz
    localparam int CLK_SLOW_MHZ = 24;
    localparam int CLK_FAST_MHZ = 48;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : fdc_cfg_pkg

// >>> rtl/floppy_config_regs.sv
// Purpose: floppy controller configuration registers over AXI4-Lite
// Assumes: one 20 MHz clock, synchronous active-low reset
// Notes: registers at byte address 4*index, data in low byte
`timescale 1ns/100ps
`default_nettype none
// Contract
// - floating pin bits read as one
// - config reachable at two indexes, shared
// - bit6 clear: drive upper bits all ones
// - bit5 sets density output polarity
// - bit4 selects 2 Mbps, 48 MHz clock
// - bit3 forces write protect
// - bit2 selects AT or PS/2 mode
// - bit0 tristates outputs when inactive
// - drive_identity bits onto drive bits 5-4 when bit6 set and drive 0 selected
// - base high bits 7-3 read zero
// - base low bits 2,0 read zero
// - irq type only bit1 writable, reset 03h
// - no media sense, second rate/drive/motor
// - force-off bit overrides activation
module floppy_config_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic write_protect_n_pin,
    input wire logic density_req,
    output logic density_select_out,
    output logic write_blocked,
    output logic at_drive_mode,
    output logic rate_2m_enable,
    output logic clock_48m_select,
    output logic outputs_tristate,
    output logic device_enabled,
    output logic drive_mode_enhanced
);
    // write channel state
    typedef enum logic [2:0] {
        W_IDLE = 3'b001,
        W_EXEC = 3'b010,
        W_RESP = 3'b100
    } wr_state_e;
    wr_state_e wr_state_ff;
    logic aw_held_ff; // address taken
    logic w_held_ff; // data taken
    logic [7:0] aw_idx_ff; // latched index
    logic aw_ok_ff; // address aligned
    logic [7:0] wd_ff; // latched low byte
    logic wstrb0_ff; // lane 0 enabled
    // registers
    logic [7:0] activate_ff;
    logic [7:0] base_hi_ff;
    logic [7:0] base_lo_ff;
    logic [7:0] irq_num_ff;
    logic [7:0] irq_type_ff;
    logic [7:0] dma_sel_ff;
    logic [7:0] cfg_ff; // shared by both config indexes
    logic [7:0] drive_identity_ff;
    logic force_off_ff;
    logic [7:0] drive_ctl_ff;
    // synchronised pins, drive view and decode
    logic wp_n_sync; // write-protect input, low active
    logic dens_sync; // high-rate request from core
    logic [7:0] drive_view; // drive control register value
    logic wr_fire; // commit a write this cycle
    logic wr_hit; // write index decoded
    logic [7:0] nxt_rdata; // read data mux
    logic rd_hit; // read index decoded

    // index decode shared by read and write
    function automatic logic idx_known(input logic [7:0] idx);
        unique case (idx)
            fdc_cfg_pkg::IDX_ACTIVATE, fdc_cfg_pkg::IDX_BASE_HI,
            fdc_cfg_pkg::IDX_BASE_LO, fdc_cfg_pkg::IDX_IRQ_NUM,
            fdc_cfg_pkg::IDX_IRQ_TYPE, fdc_cfg_pkg::IDX_DMA_SEL,
            fdc_cfg_pkg::IDX_DMA2_RPT, fdc_cfg_pkg::IDX_CFG,
            fdc_cfg_pkg::IDX_DRIVE_IDENTITY, fdc_cfg_pkg::IDX_CFG_MIRROR,
            fdc_cfg_pkg::IDX_FORCE_OFF, fdc_cfg_pkg::IDX_STATUS,
            fdc_cfg_pkg::IDX_DRIVE_CTL: idx_known = 1'b1;
            default: idx_known = 1'b0;
        endcase
    endfunction : idx_known

    // merge writable bits only
    function automatic logic [7:0] wmerge(input logic [7:0] old,
            input logic [7:0] nv, input logic [7:0] mask);
        wmerge = (old & ~mask) | (nv & mask);
    endfunction : wmerge

    // pin synchronisers
    pin_sync #(.WIDTH(2)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({write_protect_n_pin, density_req}),
        .q({wp_n_sync, dens_sync})
    );

    // drive control register view
    drive_reg_view u_view (
        .enhanced(cfg_ff[fdc_cfg_pkg::CFG_ENHANCED]),
        .drive0_sel(drive_ctl_ff[1:0] == 2'h0),
        .drive_identity(drive_identity_ff[1:0]),
        .drive_sel(drive_ctl_ff[1:0]),
        .value(drive_view)
    );

    assign wr_fire = (wr_state_ff == W_EXEC);
    assign wr_hit = aw_ok_ff && idx_known(aw_idx_ff);

    // write address/data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= W_IDLE;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_idx_ff <= 8'h00;
            aw_ok_ff <= 1'b0;
            wd_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= fdc_cfg_pkg::RESP_OKAY;
        end else begin
            unique case (wr_state_ff)
                W_IDLE: begin
                    // take address when offered
                    s_axi_awready <= !aw_held_ff && !(s_axi_awvalid
                        && s_axi_awready);
                    s_axi_wready <= !w_held_ff && !(s_axi_wvalid
                        && s_axi_wready);
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_held_ff <= 1'b1;
                        aw_idx_ff <= s_axi_awaddr[9:2];
                        aw_ok_ff <= (s_axi_awaddr[1:0] == 2'h0)
                            && (s_axi_awaddr[11:10] == 2'h0);
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_held_ff <= 1'b1;
                        wd_ff <= s_axi_wdata[7:0];
                        wstrb0_ff <= s_axi_wstrb[0];
                    end
                    if ((aw_held_ff || (s_axi_awvalid && s_axi_awready))
                        && (w_held_ff || (s_axi_wvalid && s_axi_wready)))
                    begin
                        wr_state_ff <= W_EXEC;
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                    end
                end
                W_EXEC: begin
                    // commit and raise the response on the same edge
                    s_axi_bvalid <= 1'b1;
                    s_axi_bresp <= wr_hit ? fdc_cfg_pkg::RESP_OKAY
                                          : fdc_cfg_pkg::RESP_SLVERR;
                    wr_state_ff <= W_RESP;
                end
                W_RESP: begin
                    // hold response until accepted
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        aw_held_ff <= 1'b0;
                        w_held_ff <= 1'b0;
                        wr_state_ff <= W_IDLE;
                    end
                end
                default: wr_state_ff <= W_IDLE;
            endcase
        end
    end

    // configuration register store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            activate_ff <= fdc_cfg_pkg::RST_ACTIVATE;
            base_hi_ff <= fdc_cfg_pkg::RST_BASE_HI;
            base_lo_ff <= fdc_cfg_pkg::RST_BASE_LO;
            irq_num_ff <= fdc_cfg_pkg::RST_IRQ_NUM;
            irq_type_ff <= fdc_cfg_pkg::RST_IRQ_TYPE;
            dma_sel_ff <= fdc_cfg_pkg::RST_DMA_SEL;
            cfg_ff <= fdc_cfg_pkg::RST_CFG;
            drive_identity_ff <= fdc_cfg_pkg::RST_DRIVE_IDENTITY;
            force_off_ff <= 1'b0;
            drive_ctl_ff <= fdc_cfg_pkg::RST_DRIVE_CTL;
        end else if (wr_fire && wr_hit && wstrb0_ff) begin
            unique case (aw_idx_ff)
                fdc_cfg_pkg::IDX_ACTIVATE: activate_ff <= wmerge(
                    activate_ff, wd_ff, fdc_cfg_pkg::WMASK_ACTIVATE);
                fdc_cfg_pkg::IDX_BASE_HI: base_hi_ff <= wmerge(
                    base_hi_ff, wd_ff, fdc_cfg_pkg::WMASK_BASE_HI);
                fdc_cfg_pkg::IDX_BASE_LO: base_lo_ff <= wmerge(
                    base_lo_ff, wd_ff, fdc_cfg_pkg::WMASK_BASE_LO);
                fdc_cfg_pkg::IDX_IRQ_NUM: irq_num_ff <= wd_ff;
                fdc_cfg_pkg::IDX_IRQ_TYPE: irq_type_ff <= wmerge(
                    irq_type_ff, wd_ff, fdc_cfg_pkg::WMASK_IRQ_TYPE);
                fdc_cfg_pkg::IDX_DMA_SEL: dma_sel_ff <= wd_ff;
                fdc_cfg_pkg::IDX_CFG, fdc_cfg_pkg::IDX_CFG_MIRROR:
                    cfg_ff <= wd_ff & fdc_cfg_pkg::WMASK_CFG;
                fdc_cfg_pkg::IDX_DRIVE_IDENTITY:
                    drive_identity_ff <= wd_ff & fdc_cfg_pkg::WMASK_DRIVE_IDENTITY;
                fdc_cfg_pkg::IDX_FORCE_OFF: force_off_ff <= wd_ff[0];
                fdc_cfg_pkg::IDX_DRIVE_CTL:
                    drive_ctl_ff <= {6'h00, wd_ff[1:0]};
                default: ; // read-only indexes ignore writes
            endcase
        end
    end

    // read data selection
    always_comb begin
        rd_hit = (s_axi_araddr[1:0] == 2'h0)
            && (s_axi_araddr[11:10] == 2'h0)
            && idx_known(s_axi_araddr[9:2]);
        unique case (s_axi_araddr[9:2])
            fdc_cfg_pkg::IDX_ACTIVATE: nxt_rdata = activate_ff;
            fdc_cfg_pkg::IDX_BASE_HI:
                nxt_rdata = base_hi_ff & fdc_cfg_pkg::WMASK_BASE_HI;
            fdc_cfg_pkg::IDX_BASE_LO:
                nxt_rdata = base_lo_ff & fdc_cfg_pkg::WMASK_BASE_LO;
            fdc_cfg_pkg::IDX_IRQ_NUM: nxt_rdata = irq_num_ff;
            fdc_cfg_pkg::IDX_IRQ_TYPE: nxt_rdata = irq_type_ff;
            fdc_cfg_pkg::IDX_DMA_SEL: nxt_rdata = dma_sel_ff;
            fdc_cfg_pkg::IDX_DMA2_RPT: nxt_rdata = fdc_cfg_pkg::RST_DMA2_RPT;
            fdc_cfg_pkg::IDX_CFG, fdc_cfg_pkg::IDX_CFG_MIRROR:
                nxt_rdata = cfg_ff;
            fdc_cfg_pkg::IDX_DRIVE_IDENTITY: nxt_rdata = drive_identity_ff;
            fdc_cfg_pkg::IDX_FORCE_OFF: nxt_rdata = {7'h00, force_off_ff};
            fdc_cfg_pkg::IDX_STATUS:
                nxt_rdata = {5'h00, outputs_tristate, write_blocked,
                             device_enabled};
            fdc_cfg_pkg::IDX_DRIVE_CTL:
                // pins floating while tristated read as ones
                nxt_rdata = outputs_tristate ? 8'hFF : drive_view;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= fdc_cfg_pkg::RESP_OKAY;
        end else if (s_axi_rvalid) begin
            // hold data until taken
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, nxt_rdata};
            s_axi_rresp <= rd_hit ? fdc_cfg_pkg::RESP_OKAY
                                  : fdc_cfg_pkg::RESP_SLVERR;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // controller-facing controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            device_enabled <= 1'b0;
            outputs_tristate <= 1'b0;
            write_blocked <= 1'b0;
            density_select_out <= 1'b0;
            at_drive_mode <= 1'b1;
            rate_2m_enable <= 1'b0;
            clock_48m_select <= 1'b0;
            drive_mode_enhanced <= 1'b0;
        end else begin
            device_enabled <= activate_ff[0] && !force_off_ff;
            outputs_tristate <= cfg_ff[fdc_cfg_pkg::CFG_TRISTATE]
                && !(activate_ff[0] && !force_off_ff);
            write_blocked <= cfg_ff[fdc_cfg_pkg::CFG_FORCE_WP]
                || !wp_n_sync;
            density_select_out <= cfg_ff[fdc_cfg_pkg::CFG_DENS_POL]
                ? dens_sync : !dens_sync;
            at_drive_mode <= cfg_ff[fdc_cfg_pkg::CFG_AT_MODE];
            rate_2m_enable <= cfg_ff[fdc_cfg_pkg::CFG_RATE_2M];
            clock_48m_select <= cfg_ff[fdc_cfg_pkg::CFG_RATE_2M];
            drive_mode_enhanced <= cfg_ff[fdc_cfg_pkg::CFG_ENHANCED];
        end
    end
    // no media sense, second rate, drive or motor ports exist

    a_mirror_shared: assert property (@(posedge aclk)
        disable iff (!aresetn) wr_fire && wr_hit && wstrb0_ff
        && aw_idx_ff == fdc_cfg_pkg::IDX_CFG_MIRROR
        |=> cfg_ff == ($past(wd_ff) & fdc_cfg_pkg::WMASK_CFG))
        else $error("mirror write not stored");
    a_compat_ones: assert property (@(posedge aclk)
        disable iff (!aresetn) !cfg_ff[fdc_cfg_pkg::CFG_ENHANCED]
        |-> drive_view[7:2] == fdc_cfg_pkg::COMPAT_UPPER)
        else $error("compat upper bits not ones");
    a_density_pol: assert property (@(posedge aclk)
        disable iff (!aresetn) $past(aresetn) |-> density_select_out ==
        ($past(cfg_ff[fdc_cfg_pkg::CFG_DENS_POL]) ? $past(dens_sync)
        : !$past(dens_sync)))
        else $error("density polarity wrong");
    a_clock_sel: assert property (@(posedge aclk)
        disable iff (!aresetn) $past(aresetn)
        |-> clock_48m_select == $past(cfg_ff[fdc_cfg_pkg::CFG_RATE_2M]))
        else $error("clock select wrong");
    a_force_wp: assert property (@(posedge aclk)
        disable iff (!aresetn) cfg_ff[fdc_cfg_pkg::CFG_FORCE_WP]
        && $stable(cfg_ff) |=> write_blocked)
        else $error("forced protect missing");
    a_tristate_on: assert property (@(posedge aclk)
        disable iff (!aresetn) $past(aresetn) |-> outputs_tristate ==
        ($past(cfg_ff[fdc_cfg_pkg::CFG_TRISTATE])
        && !($past(activate_ff[0]) && !$past(force_off_ff))))
        else $error("tristate control wrong");
    a_id_reflect: assert property (@(posedge aclk)
        disable iff (!aresetn) cfg_ff[fdc_cfg_pkg::CFG_ENHANCED]
        && drive_ctl_ff[1:0] == 2'h0
        |-> drive_view[5:4] == drive_identity_ff[1:0])
        else $error("drive_identity not reflected");
    a_base_hi_zero: assert property (@(posedge aclk)
        disable iff (!aresetn) (base_hi_ff & ~fdc_cfg_pkg::WMASK_BASE_HI)
        == 8'h00)
        else $error("base high upper bits set");
    a_base_lo_zero: assert property (@(posedge aclk)
        disable iff (!aresetn) (base_lo_ff & ~fdc_cfg_pkg::WMASK_BASE_LO)
        == 8'h00)
        else $error("base low fixed bits changed");
    a_irq_type_ro: assert property (@(posedge aclk)
        disable iff (!aresetn) (irq_type_ff & ~fdc_cfg_pkg::WMASK_IRQ_TYPE)
        == (fdc_cfg_pkg::RST_IRQ_TYPE & ~fdc_cfg_pkg::WMASK_IRQ_TYPE))
        else $error("irq type ro bits changed");
    a_force_off: assert property (@(posedge aclk)
        disable iff (!aresetn) force_off_ff ##1 force_off_ff
        |-> !device_enabled)
        else $error("force off ignored");
    a_reserved_zero: assert property (@(posedge aclk)
        disable iff (!aresetn) (cfg_ff & ~fdc_cfg_pkg::WMASK_CFG) == 8'h00
        && (drive_identity_ff & ~fdc_cfg_pkg::WMASK_DRIVE_IDENTITY) == 8'h00)
        else $error("reserved bits set");
    a_float_ones: assert property (@(posedge aclk)
        disable iff (!aresetn) s_axi_arvalid && s_axi_arready
        && s_axi_araddr == {2'h0, fdc_cfg_pkg::IDX_DRIVE_CTL, 2'h0}
        && outputs_tristate |=> s_axi_rdata == 32'h0000_00FF)
        else $error("floating bits not one");
endmodule : floppy_config_regs
`default_nettype wire

// >>> rtl/pin_sync.sv
// Purpose: two-stage synchroniser for a group of pin levels
// Assumes: inputs asynchronous to aclk
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff; // first stage
    logic [WIDTH-1:0] sync_ff; // second stage

    // double flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end
    assign q = sync_ff;
endmodule : pin_sync
`default_nettype wire
